// ### src/pdm_regs.svh
`ifndef PDM_REGS_SVH
`define PDM_REGS_SVH

// program space vectors
`define PDM_RESET_VECTOR   13'h0000
`define PDM_INT_VECTOR     13'h0004
`define PDM_PROG_WORDS     8192

// status register fields and core register reset values
`define PDM_BANK_HI_BIT    6
`define PDM_BANK_LO_BIT    5
`define PDM_IND_BANK_BIT   7
`define PDM_STATUS_RESET   8'h00
`define PDM_POINTER_RESET  8'h00
`define PDM_LATCH_RESET    8'h00

// local offsets of the mirrored core registers
`define PDM_OFS_INDIRECT   7'h00
`define PDM_OFS_PC_LOW     7'h02
`define PDM_OFS_STATUS     7'h03
`define PDM_OFS_POINTER    7'h04
`define PDM_OFS_LATCH      7'h0a

// bank layout
`define PDM_BANK_TOP       7'h7f
`define PDM_GPR_BASE       7'h20
`define PDM_COMMON_BASE    7'h70
`define PDM_BANK_GPR       9'h050
`define PDM_COMMON_IDX     9'h140
`define PDM_GPR_BYTES      336

`endif

// ### src/pdm_pkg.sv
`default_nettype none
package pdm_pkg;
	typedef enum logic [2:0] {
		TGT_INDIRECT,
		TGT_PC_LOW,
		TGT_STATUS,
		TGT_POINTER,
		TGT_LATCH,
		TGT_EXT_SFR,
		TGT_GPR
	} pdm_target_t;

	typedef struct packed {
		logic [12:0] pc;
		logic [13:0] instr;
		logic [7:0]  status;
		logic [7:0]  pointer;
		logic [7:0]  prog_latch;
		logic [7:0]  rdata;
		logic        valid;
	} pdm_state_t;
endpackage : pdm_pkg
`default_nettype wire

// ### src/pdm_dec_if.sv
`default_nettype none
interface pdm_dec_if;
	logic [8:0]          full_addr;
	pdm_pkg::pdm_target_t target;
	logic [8:0]          gpr_idx;

	modport core
	(
		output full_addr,
		input  target,
		input  gpr_idx
	);

	modport dec
	(
		input  full_addr,
		output target,
		output gpr_idx
	);
endinterface : pdm_dec_if
`default_nettype wire

// ### src/pdm_data_decode.sv
`include "pdm_regs.svh"
`default_nettype none
module pdm_data_decode
(
	pdm_dec_if.dec d
);
	logic [1:0] bank;
	logic [6:0] loc;
	logic [8:0] bank_base;

	assign bank = d.full_addr[8:7];
	assign loc  = d.full_addr[6:0];

	always_comb
	begin
		bank_base = 9'h000;
		for (int i = 0; i < 4; i++)
		begin
			if (bank == i[1:0])
			begin
				bank_base = 9'(i * `PDM_BANK_GPR);
			end
		end
	end

	// core registers sit at the same local offset in every bank
	always_comb
	begin
		d.gpr_idx = 9'h000;
		if (loc < `PDM_GPR_BASE)
		begin
			unique case (loc)
				`PDM_OFS_INDIRECT: d.target = pdm_pkg::TGT_INDIRECT;
				`PDM_OFS_PC_LOW:   d.target = pdm_pkg::TGT_PC_LOW;
				`PDM_OFS_STATUS:   d.target = pdm_pkg::TGT_STATUS;
				`PDM_OFS_POINTER:  d.target = pdm_pkg::TGT_POINTER;
				`PDM_OFS_LATCH:    d.target = pdm_pkg::TGT_LATCH;
				default:           d.target = pdm_pkg::TGT_EXT_SFR;
			endcase
		end
		else
		begin
			d.target = pdm_pkg::TGT_GPR;
			if (loc >= `PDM_COMMON_BASE)
			begin
				// top of every bank reaches one shared block
				d.gpr_idx = `PDM_COMMON_IDX + {2'b00, loc - `PDM_COMMON_BASE};
			end
			else
			begin
				d.gpr_idx = bank_base + {2'b00, loc - `PDM_GPR_BASE};
			end
		end
	end
endmodule : pdm_data_decode
`default_nettype wire

// ### src/pdm_memory_map.sv
`include "pdm_regs.svh"
`default_nettype none
// Contract
// - 13-bit counter, 8K by 14-bit program space
// - implemented program size 8K or 4K words
// - fetch above implemented size wraps, no error
// - fetch starts at address zero after reset
// - taken interrupt loads counter with four
// - status bits six, five select bank
// - each bank spans 128 local byte locations
// - special registers low, general RAM above
// - mirrored registers alias one physical register
// - direct or indirect pointer data access
// - separate program and data buses, concurrent
module pdm_memory_map
#(
	parameter int PROG_WORDS = `PDM_PROG_WORDS
)
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// program side
	input  wire logic        fetch_en,
	input  wire logic        branch_en,
	input  wire logic [12:0] branch_target,
	input  wire logic        int_take,
	output logic      [12:0] pc,
	output logic      [12:0] prog_addr,
	input  wire logic [13:0] prog_rdata,
	output logic      [13:0] instr,
	// data side
	input  wire logic        data_req,
	input  wire logic        data_we,
	input  wire logic        data_indirect,
	input  wire logic [6:0]  data_addr,
	input  wire logic [7:0]  data_wdata,
	output logic      [7:0]  data_rdata,
	output logic             data_valid,
	// peripheral special registers kept outside
	output logic             ext_sfr_sel,
	output logic             ext_sfr_we,
	output logic      [8:0]  ext_sfr_addr,
	output logic      [7:0]  ext_sfr_wdata,
	input  wire logic [7:0]  ext_sfr_rdata,
	// state seen by the core
	output logic      [7:0]  status,
	output logic      [7:0]  indirect_pointer_reg,
	output logic      [1:0]  bank
);
	localparam logic [12:0] PC_MASK = 13'(PROG_WORDS - 1);

	pdm_pkg::pdm_state_t st_ff;
	pdm_pkg::pdm_state_t nxt_st;

	logic [7:0] gpr_mem [`PDM_GPR_BYTES];

	logic       bank_select_high;
	logic       bank_select_low;
	logic [8:0] acc_addr;
	logic       acc_write;
	logic [7:0] acc_rdata;

	pdm_dec_if dec_bus ();

	pdm_data_decode u_decode
	(
		.d (dec_bus.dec)
	);

	assign bank_select_high = st_ff.status[`PDM_BANK_HI_BIT];
	assign bank_select_low  = st_ff.status[`PDM_BANK_LO_BIT];
	assign bank             = {bank_select_high, bank_select_low};

	// direct or pointer addressing
	always_comb
	begin
		if (data_indirect)
		begin
			acc_addr = {st_ff.status[`PDM_IND_BANK_BIT], st_ff.pointer};
		end
		else
		begin
			acc_addr = {bank_select_high, bank_select_low, data_addr};
		end
	end

	assign dec_bus.full_addr = acc_addr;
	assign acc_write         = data_req && data_we;

	// peripheral registers; the pointer slot itself never reaches out
	assign ext_sfr_sel   = data_req && (dec_bus.target == pdm_pkg::TGT_EXT_SFR);
	assign ext_sfr_we    = ext_sfr_sel && data_we;
	assign ext_sfr_addr  = acc_addr;
	assign ext_sfr_wdata = data_wdata;

	// read mux over the mirrored core registers and the RAM
	always_comb
	begin
		unique case (dec_bus.target)
			pdm_pkg::TGT_INDIRECT: acc_rdata = 8'h00;
			pdm_pkg::TGT_PC_LOW:   acc_rdata = st_ff.pc[7:0];
			pdm_pkg::TGT_STATUS:   acc_rdata = st_ff.status;
			pdm_pkg::TGT_POINTER:  acc_rdata = st_ff.pointer;
			pdm_pkg::TGT_LATCH:    acc_rdata = st_ff.prog_latch;
			pdm_pkg::TGT_EXT_SFR:  acc_rdata = ext_sfr_rdata;
			pdm_pkg::TGT_GPR:      acc_rdata = gpr_mem[dec_bus.gpr_idx];
			default:               acc_rdata = 8'h00;
		endcase
	end

	always_comb
	begin
		nxt_st       = st_ff;
		nxt_st.valid = data_req;
		if (data_req)
		begin
			nxt_st.rdata = acc_rdata;
		end

		// fetch path uses its own bus, independent of the data access
		if (fetch_en)
		begin
			nxt_st.instr = prog_rdata;
		end

		// register writes through any bank alias land in one place
		if (acc_write)
		begin
			unique case (dec_bus.target)
				pdm_pkg::TGT_STATUS:
				begin
					nxt_st.status = data_wdata;
				end
				pdm_pkg::TGT_POINTER:
				begin
					nxt_st.pointer = data_wdata;
				end
				pdm_pkg::TGT_LATCH:
				begin
					nxt_st.prog_latch = data_wdata;
				end
				default:
				begin
					nxt_st.status = st_ff.status;
				end
			endcase
		end

		// counter priority: interrupt, branch, low byte write, advance
		if (int_take)
		begin
			nxt_st.pc = `PDM_INT_VECTOR;
		end
		else if (branch_en)
		begin
			nxt_st.pc = branch_target;
		end
		else if (acc_write && (dec_bus.target == pdm_pkg::TGT_PC_LOW))
		begin
			nxt_st.pc = {st_ff.prog_latch[4:0], data_wdata};
		end
		else if (fetch_en)
		begin
			nxt_st.pc = st_ff.pc + 13'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_ff.pc         <= `PDM_RESET_VECTOR;
			st_ff.instr      <= 14'h0000;
			st_ff.status     <= `PDM_STATUS_RESET;
			st_ff.pointer    <= `PDM_POINTER_RESET;
			st_ff.prog_latch <= `PDM_LATCH_RESET;
			st_ff.rdata      <= 8'h00;
			st_ff.valid      <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// general purpose RAM, one block per bank plus a shared block reached from all banks
	always_ff @(posedge core_clk)
	begin
		if (acc_write && (dec_bus.target == pdm_pkg::TGT_GPR))
		begin
			gpr_mem[dec_bus.gpr_idx] <= data_wdata;
		end
	end

	// unused high counter bits fold back onto the built array
	assign prog_addr = st_ff.pc & PC_MASK;

	assign pc                   = st_ff.pc;
	assign instr                = st_ff.instr;
	assign data_rdata           = st_ff.rdata;
	assign data_valid           = st_ff.valid;
	assign status               = st_ff.status;
	assign indirect_pointer_reg = st_ff.pointer;
endmodule : pdm_memory_map
`default_nettype wire

// ### bench/pdm_map_properties.sv
`default_nettype none
module pdm_map_properties
#(
	parameter int PROG_WORDS = 8192
)
(
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        fetch_en,
	input wire logic        branch_en,
	input wire logic [12:0] branch_target,
	input wire logic        int_take,
	input wire logic [12:0] pc,
	input wire logic [12:0] prog_addr,
	input wire logic        data_req,
	input wire logic        data_indirect,
	input wire logic [6:0]  data_addr,
	input wire logic        data_valid,
	input wire logic        ext_sfr_sel,
	input wire logic [7:0]  status,
	input wire logic [1:0]  bank
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	AST_INT_VECTOR: assert property (int_take |=> pc == 13'h0004)
		else $error("pc missed interrupt vector");
	AST_WRAP: assert property (prog_addr == 13'(pc & (PROG_WORDS - 1)))
		else $error("program address not wrapped");
	AST_BANK: assert property (bank == {status[6], status[5]})
		else $error("bank not from status bits");
	AST_STEP: assert property (fetch_en && !int_take && !branch_en && !data_req |=>
		pc == $past(pc) + 13'h1) else $error("pc did not advance");
	AST_BRANCH: assert property (branch_en && !int_take |=> pc == $past(branch_target))
		else $error("branch target not loaded");
	AST_RESET_PC: assert property ($rose(reset_n) |-> pc == 13'h0000)
		else $error("pc not zero after reset");
	AST_VALID: assert property (data_req |=> data_valid)
		else $error("data access not answered");
	AST_NO_VALID: assert property (!data_req |=> !data_valid)
		else $error("answer without access");
	AST_RAM_LOCAL: assert property (data_req && !data_indirect && data_addr >= 7'h20 |->
		!ext_sfr_sel) else $error("ram address sent to special register port");
endmodule : pdm_map_properties
bind pdm_memory_map pdm_map_properties #(.PROG_WORDS(PROG_WORDS)) chk_u
(
	.core_clk      (core_clk),
	.reset_n       (reset_n),
	.fetch_en      (fetch_en),
	.branch_en     (branch_en),
	.branch_target (branch_target),
	.int_take      (int_take),
	.pc            (pc),
	.prog_addr     (prog_addr),
	.data_req      (data_req),
	.data_indirect (data_indirect),
	.data_addr     (data_addr),
	.data_valid    (data_valid),
	.ext_sfr_sel   (ext_sfr_sel),
	.status        (status),
	.bank          (bank)
);
`default_nettype wire

// ### bench/pdm_prog_mem.sv
`default_nettype none
module pdm_prog_mem
(
	input wire logic [12:0] prog_addr,
	output logic     [13:0] prog_rdata,
	input wire logic        ext_sfr_sel,
	input wire logic [8:0]  ext_sfr_addr,
	output logic     [7:0]  ext_sfr_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	assign prog_rdata = {1'b1, prog_addr ^ 13'h0a5a};
	// unselected peripheral bus shows inverted pattern, not stale data
	assign ext_sfr_rdata = ext_sfr_sel ? ext_sfr_addr[7:0] : ~ext_sfr_addr[7:0];
endmodule : pdm_prog_mem
`default_nettype wire

// ### bench/program_data_memory_map_bench.sv
`default_nettype none
`define PDM_CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
	$display("wrong value t=%0t got=%h exp=%h", $time, (a), (e)); end end
module program_data_memory_map_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, reset_n = 1'b0, fetch_en = 1'b0, branch_en = 1'b0, int_take = 1'b0;
	logic data_req = 1'b0, data_we = 1'b0, data_indirect = 1'b0;
	logic [12:0] branch_target = 13'h0000, pc, prog_addr;
	logic [13:0] prog_rdata, instr;
	logic [6:0]  data_addr = 7'h00;
	logic [7:0]  data_wdata = 8'h00, data_rdata, ext_sfr_wdata, ext_sfr_rdata, rd, sfr_d;
	logic [7:0]  status, indirect_pointer_reg;
	logic [8:0]  ext_sfr_addr, sfr_a;
	logic [1:0]  bank;
	logic        data_valid, ext_sfr_sel, ext_sfr_we, sfr_s, sfr_w;
	int          errors = 0, samples_checked = 0, cyc = 0;
	pdm_memory_map #(.PROG_WORDS(4096)) dut_u
	(
		.core_clk             (core_clk),
		.reset_n              (reset_n),
		.fetch_en             (fetch_en),
		.branch_en            (branch_en),
		.branch_target        (branch_target),
		.int_take             (int_take),
		.pc                   (pc),
		.prog_addr            (prog_addr),
		.prog_rdata           (prog_rdata),
		.instr                (instr),
		.data_req             (data_req),
		.data_we              (data_we),
		.data_indirect        (data_indirect),
		.data_addr            (data_addr),
		.data_wdata           (data_wdata),
		.data_rdata           (data_rdata),
		.data_valid           (data_valid),
		.ext_sfr_sel          (ext_sfr_sel),
		.ext_sfr_we           (ext_sfr_we),
		.ext_sfr_addr         (ext_sfr_addr),
		.ext_sfr_wdata        (ext_sfr_wdata),
		.ext_sfr_rdata        (ext_sfr_rdata),
		.status               (status),
		.indirect_pointer_reg (indirect_pointer_reg),
		.bank                 (bank)
	);
	pdm_prog_mem mem_u
	(
		.prog_addr     (prog_addr),
		.prog_rdata    (prog_rdata),
		.ext_sfr_sel   (ext_sfr_sel),
		.ext_sfr_addr  (ext_sfr_addr),
		.ext_sfr_rdata (ext_sfr_rdata)
	);
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			errors++;
			conclude();
		end
	end
	function automatic logic [13:0] mem(input logic [12:0] a);
		return {1'b1, a ^ 13'h0a5a};
	endfunction : mem
	task automatic step(input logic f, b, i, input logic [12:0] t);
		@(posedge core_clk);
		fetch_en <= f;
		branch_en <= b;
		int_take <= i;
		branch_target <= t;
		@(posedge core_clk);
		fetch_en <= 1'b0;
		branch_en <= 1'b0;
		int_take <= 1'b0;
		#1;
	endtask : step
	task automatic dacc(input logic we, ind, input logic [6:0] a, input logic [7:0] wd);
		@(posedge core_clk);
		data_req <= 1'b1;
		data_we <= we;
		data_indirect <= ind;
		data_addr <= a;
		data_wdata <= wd;
		@(negedge core_clk);
		sfr_a = ext_sfr_addr;
		sfr_s = ext_sfr_sel;
		sfr_w = ext_sfr_we;
		sfr_d = ext_sfr_wdata;
		@(posedge core_clk);
		data_req <= 1'b0;
		#1;
		rd = data_rdata;
		`PDM_CHK(data_valid, 1'b1)
	endtask : dacc
	task automatic t_prog();
		`PDM_CHK(pc, 13'h0000)
		step(1'b1, 1'b0, 1'b0, 13'h0000);
		`PDM_CHK(instr, mem(13'h0000))
		step(1'b0, 1'b1, 1'b0, 13'h0fff);
		`PDM_CHK(prog_addr, 13'h0fff)
		step(1'b1, 1'b0, 1'b0, 13'h0000);
		`PDM_CHK(pc, 13'h1000)
		`PDM_CHK(prog_addr, 13'h0000)
		step(1'b1, 1'b1, 1'b1, 13'h0100);
		`PDM_CHK(pc, 13'h0004)
		$display("test prog done");
	endtask : t_prog
	task automatic t_data();
		for (int b = 0; b < 4; b++)
		begin
			dacc(1'b1, 1'b0, 7'h03, 8'(b << 5));
			`PDM_CHK(bank, 2'(b))
			dacc(1'b1, 1'b0, 7'h20, 8'(8'h10 + b));
		end
		for (int b = 0; b < 4; b++)
		begin
			dacc(1'b1, 1'b0, 7'h03, 8'(b << 5));
			dacc(1'b0, 1'b0, 7'h20, 8'h00);
			`PDM_CHK(rd, 8'(8'h10 + b))
			dacc(1'b0, 1'b0, 7'h05, 8'h00);
			`PDM_CHK(sfr_s, 1'b1)
			`PDM_CHK(sfr_a, {b[1:0], 7'h05})
			`PDM_CHK(rd, {b[0], 7'h05})
		end
		dacc(1'b1, 1'b0, 7'h7f, 8'h3c);
		dacc(1'b1, 1'b0, 7'h03, 8'h00);
		dacc(1'b0, 1'b0, 7'h7f, 8'h00);
		`PDM_CHK(rd, 8'h3c)
		dacc(1'b1, 1'b0, 7'h04, 8'h20);
		`PDM_CHK(indirect_pointer_reg, 8'h20)
		dacc(1'b1, 1'b0, 7'h03, 8'h40);
		`PDM_CHK(status, 8'h40)
		dacc(1'b0, 1'b0, 7'h04, 8'h00);
		`PDM_CHK(rd, 8'h20)
		fork
			step(1'b1, 1'b0, 1'b0, 13'h0000);
			dacc(1'b0, 1'b1, 7'h00, 8'h00);
		join
		`PDM_CHK(rd, 8'h10)
		`PDM_CHK(pc, 13'h0005)
		$display("test data done");
	endtask : t_data
	task automatic t_core();
		dacc(1'b1, 1'b0, 7'h06, 8'h5a);
		`PDM_CHK(sfr_s, 1'b1)
		`PDM_CHK(sfr_w, 1'b1)
		`PDM_CHK(sfr_d, 8'h5a)
		`PDM_CHK(sfr_a, 9'h106)
		dacc(1'b1, 1'b0, 7'h00, 8'hff);
		`PDM_CHK(sfr_s, 1'b0)
		dacc(1'b0, 1'b0, 7'h00, 8'h00);
		`PDM_CHK(rd, 8'h00)
		dacc(1'b1, 1'b0, 7'h0a, 8'h01);
		dacc(1'b1, 1'b0, 7'h03, 8'h60);
		dacc(1'b1, 1'b0, 7'h02, 8'h23);
		`PDM_CHK(pc, 13'h0123)
		dacc(1'b0, 1'b0, 7'h02, 8'h00);
		`PDM_CHK(rd, 8'h23)
		$display("test core done");
	endtask : t_core
	task automatic conclude();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
		begin
			$display("NO MISMATCHES");
		end
		else
		begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude
	initial
	begin
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		t_prog();
		t_data();
		t_core();
		conclude();
	end
endmodule : program_data_memory_map_bench
`default_nettype wire
